// [pkg/fpb_pkg.sv]
// Shared constants, memory map and state type for the filter parameter bank access block.
package fpb_pkg;

    localparam int          FPB_NBANK      = 3;
    localparam int          FPB_NPARAM     = 5;
    localparam int          FPB_NINSTR     = 128;
    localparam int          FPB_NCOPY      = 6;
    localparam int          FPB_BANK_W     = 2;
    localparam int          FPB_SEL_W      = 3;
    localparam logic [31:0] FPB_PARAM_BASE = 32'hF002_0000;
    localparam logic [31:0] FPB_STATE_BASE = 32'hF003_0000;
    localparam logic [31:0] FPB_PROG_BASE  = 32'hF004_0000;
    localparam logic [31:0] FPB_MEM_STEP   = 32'h0000_0080;
    localparam logic [31:0] FPB_NREGION    = 32'h0000_000F;
    localparam logic [31:0] FPB_ZERO_WORD  = 32'h0000_0000;

    // Safeload staging select: index word, then parameter words 0 to 4.
    localparam logic [2:0] FPB_SEL_INDEX   = 3'h0;
    localparam logic [2:0] FPB_SEL_P0      = 3'h1;

    // Source and target bank of each copy command bit (A=0, B=1, C=2).
    localparam logic [1:0] FPB_COPY_SRC [FPB_NCOPY] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    localparam logic [1:0] FPB_COPY_TGT [FPB_NCOPY] = '{2'h1, 2'h2, 2'h0, 2'h2, 2'h0, 2'h1};

    typedef enum logic [1:0]
    {
        FPB_IDLE = 2'b00,
        FPB_WAIT = 2'b01,
        FPB_COPY = 2'b10
    } fpb_copy_state_t;

endpackage

// [rtl/fpb_bank_access.sv]
// Parameter bank storage with copy, access arbitration and safeload for the filter core.
// Summary of operation
// - Six copy bits, one per bank pair.
// - Copy waits for frame start, then transfers.
// - Copy completes at the second frame start, within two frames.
// - Copy into active bank is ignored.
// - Enabled, not running: all banks readable.
// - Running: active bank direct reads return zero.
// - Running, same-cycle same-location read: processor wins.
// - Running: direct writes only to inactive banks.
// - Same-location write clash: only processor write.
// - Five 128-word memories per bank, mapped.
// - Trigger writes five staged words next frame.
// - Processor has its own safeload set.
// - Disallowed accesses flagged as error events.
// - One active bank, selectable while running.
// - Processor safeload applies next frame, no trigger.
`timescale 1ns/1ns
module fpb_bank_access
    import fpb_pkg::*;
#(
    parameter int NINSTR = FPB_NINSTR
)
(
    input  wire logic                  clock_i,
    input  wire logic                  nrst_i,
    input  wire logic                  core_enable_i,
    input  wire logic                  core_running_i,
    input  wire logic                  frame_start_i,
    input  wire logic [FPB_BANK_W-1:0] active_bank_select_i,
    input  wire logic [FPB_NCOPY-1:0]  bank_copy_cmd_i,
    output logic      [FPB_NCOPY-1:0]  bank_copy_cmd_o,
    input  wire logic                  cp_rd_i,
    input  wire logic                  cp_wr_i,
    input  wire logic [31:0]           cp_addr_i,
    input  wire logic [31:0]           cp_wdata_i,
    output logic      [31:0]           cp_rdata_o,
    input  wire logic                  pr_rd_i,
    input  wire logic                  pr_wr_i,
    input  wire logic [31:0]           pr_addr_i,
    input  wire logic [31:0]           pr_wdata_i,
    output logic      [31:0]           pr_rdata_o,
    input  wire logic                  core_memory_read_instr_i,
    input  wire logic [31:0]           mr_addr_i,
    output logic      [31:0]           mr_rdata_o,
    input  wire logic                  sl_wr_i,
    input  wire logic [FPB_SEL_W-1:0]  sl_sel_i,
    input  wire logic [31:0]           sl_wdata_i,
    input  wire logic                  safeload_trigger_i,
    output logic                       safeload_trigger_o,
    input  wire logic                  psl_wr_i,
    input  wire logic [FPB_SEL_W-1:0]  psl_sel_i,
    input  wire logic [31:0]           psl_wdata_i,
    output logic                       cp_access_err_o,
    output logic                       pr_access_err_o
);

    localparam int NWORD = NINSTR * FPB_NPARAM;
    localparam int IW    = $clog2(NINSTR);

    logic [31:0]           mem_r [FPB_NBANK][NWORD];
    fpb_copy_state_t       copy_state_r;
    logic [FPB_NCOPY-1:0]  copy_pend_r;
    logic [FPB_BANK_W-1:0] copy_src_r;
    logic [FPB_BANK_W-1:0] copy_tgt_r;
    logic [IW-1:0]         sl_index_r;
    logic [31:0]           sl_param_r [FPB_NPARAM];
    logic                  sl_armed_r;
    logic [IW-1:0]         psl_index_r;
    logic [31:0]           psl_param_r [FPB_NPARAM];
    logic                  psl_armed_r;

    // Byte-free decode: each parameter memory spans one 0x80 step of word addresses.
    function automatic logic [FPB_BANK_W+31:0] fpb_decode(input logic [31:0] addr);
        logic [31:0] off;
        logic [31:0] region;
        logic [31:0] bank;
        logic [31:0] entry;
        off    = addr - FPB_PARAM_BASE;
        region = off / FPB_MEM_STEP;
        bank   = region / FPB_NPARAM;
        entry  = (region % FPB_NPARAM) * NINSTR + (off % FPB_MEM_STEP);
        if (addr < FPB_PARAM_BASE || region >= FPB_NREGION
            || (off % FPB_MEM_STEP) >= 32'(NINSTR))
            return {FPB_BANK_W'(3), 32'h0000_0000};
        return {bank[FPB_BANK_W-1:0], entry};
    endfunction

    logic [FPB_BANK_W-1:0] cp_bank, pr_bank, mr_bank;
    logic [31:0]           cp_ent, pr_ent, mr_ent;
    logic                  cp_map, pr_map, mr_map;
    logic                  cp_lock, pr_lock, mr_lock;
    logic                  same_loc;
    logic                  pr_wr_ok, cp_wr_ok;
    logic                  frame_fire_copy, copy_ok_now;
    logic [FPB_NCOPY-1:0]  cmd_first;

    // Address decode; bank code 3 marks an address outside the parameter banks.
    assign {cp_bank, cp_ent} = fpb_decode(cp_addr_i);
    assign {pr_bank, pr_ent} = fpb_decode(pr_addr_i);
    assign {mr_bank, mr_ent} = fpb_decode(mr_addr_i);
    assign cp_map   = (cp_bank < FPB_BANK_W'(FPB_NBANK));
    assign pr_map   = (pr_bank < FPB_BANK_W'(FPB_NBANK));
    assign mr_map   = (mr_bank < FPB_BANK_W'(FPB_NBANK));

    // The active bank is locked against direct access only while the core runs.
    assign cp_lock  = core_running_i && (cp_bank == active_bank_select_i);
    assign pr_lock  = core_running_i && (pr_bank == active_bank_select_i);
    assign mr_lock  = core_running_i && (mr_bank == active_bank_select_i);
    assign same_loc = (cp_addr_i == pr_addr_i);

    // Write permission; the processor wins a same-location clash.
    assign pr_wr_ok = pr_wr_i && pr_map && !pr_lock;
    assign cp_wr_ok = cp_wr_i && cp_map && !cp_lock
                      && !(core_running_i && pr_wr_ok && same_loc);

    // Lowest numbered command bit wins if several are written at once.
    assign cmd_first = bank_copy_cmd_i & (~bank_copy_cmd_i + FPB_NCOPY'(1));
    assign frame_fire_copy = frame_start_i && (copy_state_r == FPB_COPY);
    assign copy_ok_now     = (copy_tgt_r != active_bank_select_i);

    // Copy sequencer: arm on command, wait one frame start, then copy and finish together at the next.
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            copy_state_r <= FPB_IDLE;
            copy_pend_r  <= '0;
            copy_src_r   <= '0;
            copy_tgt_r   <= '0;
        end
        else
        begin
            unique case (copy_state_r)
                FPB_IDLE:
                begin
                    for (int i = 0; i < FPB_NCOPY; i++)
                    begin
                        if (cmd_first[i] && FPB_COPY_TGT[i] != active_bank_select_i)
                        begin
                            copy_state_r <= FPB_WAIT;
                            copy_pend_r  <= cmd_first;
                            copy_src_r   <= FPB_COPY_SRC[i];
                            copy_tgt_r   <= FPB_COPY_TGT[i];
                        end
                    end
                end
                FPB_WAIT:
                begin
                    if (frame_start_i)
                        copy_state_r <= FPB_COPY;
                end
                FPB_COPY:
                begin
                    if (frame_start_i)
                    begin
                        copy_state_r <= FPB_IDLE;
                        copy_pend_r  <= '0;
                    end
                end
                default:
                begin
                    copy_state_r <= FPB_IDLE;
                    copy_pend_r  <= '0;
                end
            endcase
        end
    end

    // Control-port safeload staging; the trigger arms and self-clears when applied.
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sl_index_r <= '0;
            sl_param_r <= '{default: '0};
            sl_armed_r <= 1'b0;
        end
        else
        begin
            if (sl_wr_i && sl_sel_i == FPB_SEL_INDEX)
                sl_index_r <= sl_wdata_i[IW-1:0];
            for (int p = 0; p < FPB_NPARAM; p++)
            begin
                if (sl_wr_i && sl_sel_i == FPB_SEL_P0 + FPB_SEL_W'(p))
                    sl_param_r[p] <= sl_wdata_i;
            end
            if (safeload_trigger_i)
                sl_armed_r <= 1'b1;
            else if (frame_start_i)
                sl_armed_r <= 1'b0;
        end
    end

    // Processor safeload set; any write to it arms an update at the next frame.
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            psl_index_r <= '0;
            psl_param_r <= '{default: '0};
            psl_armed_r <= 1'b0;
        end
        else
        begin
            if (psl_wr_i && psl_sel_i == FPB_SEL_INDEX)
                psl_index_r <= psl_wdata_i[IW-1:0];
            for (int p = 0; p < FPB_NPARAM; p++)
            begin
                if (psl_wr_i && psl_sel_i == FPB_SEL_P0 + FPB_SEL_W'(p))
                    psl_param_r[p] <= psl_wdata_i;
            end
            if (psl_wr_i)
                psl_armed_r <= 1'b1;
            else if (frame_start_i)
                psl_armed_r <= 1'b0;
        end
    end

    // Storage: per word, copy beats safeload, safeload beats direct writes.
    for (genvar b = 0; b < FPB_NBANK; b++)
    begin : g_bank
        for (genvar w = 0; w < NWORD; w++)
        begin : g_word
            localparam int P = w / NINSTR;
            localparam int N = w % NINSTR;
            always_ff @(posedge clock_i or negedge nrst_i)
            begin
                if (!nrst_i)
                    mem_r[b][w] <= FPB_ZERO_WORD;
                else if (frame_fire_copy && copy_ok_now && copy_tgt_r == FPB_BANK_W'(b))
                    mem_r[b][w] <= mem_r[copy_src_r][w];
                else if (frame_start_i && psl_armed_r && active_bank_select_i == FPB_BANK_W'(b)
                         && psl_index_r == IW'(N))
                    mem_r[b][w] <= psl_param_r[P];
                else if (frame_start_i && sl_armed_r && active_bank_select_i == FPB_BANK_W'(b)
                         && sl_index_r == IW'(N))
                    mem_r[b][w] <= sl_param_r[P];
                else if (pr_wr_ok && pr_bank == FPB_BANK_W'(b) && pr_ent == 32'(w))
                    mem_r[b][w] <= pr_wdata_i;
                else if (cp_wr_ok && cp_bank == FPB_BANK_W'(b) && cp_ent == 32'(w))
                    mem_r[b][w] <= cp_wdata_i;
            end
        end
    end

    // Read data registers; locked or unmapped reads return zero.
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cp_rdata_o <= FPB_ZERO_WORD;
            pr_rdata_o <= FPB_ZERO_WORD;
            mr_rdata_o <= FPB_ZERO_WORD;
        end
        else
        begin
            if (cp_rd_i)
                cp_rdata_o <= (cp_map && !cp_lock && !(core_running_i && pr_rd_i && same_loc))
                              ? mem_r[cp_bank][cp_ent[$clog2(NWORD)-1:0]] : FPB_ZERO_WORD;
            if (pr_rd_i)
                pr_rdata_o <= (pr_map && !pr_lock)
                              ? mem_r[pr_bank][pr_ent[$clog2(NWORD)-1:0]] : FPB_ZERO_WORD;
            if (core_memory_read_instr_i)
                mr_rdata_o <= (mr_map && !mr_lock)
                              ? mem_r[mr_bank][mr_ent[$clog2(NWORD)-1:0]] : FPB_ZERO_WORD;
        end
    end

    // Access-error pulses for active-bank or lost-clash accesses.
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cp_access_err_o <= 1'b0;
            pr_access_err_o <= 1'b0;
        end
        else
        begin
            cp_access_err_o <= ((cp_rd_i || cp_wr_i) && cp_map && cp_lock)
                               || (core_running_i && cp_rd_i && pr_rd_i && same_loc)
                               || (core_running_i && cp_wr_i && pr_wr_ok && same_loc);
            pr_access_err_o <= (pr_rd_i || pr_wr_i) && pr_map && pr_lock;
        end
    end

    // Status: pending copy bit and armed trigger, cleared on completion.
    assign bank_copy_cmd_o    = copy_pend_r;
    assign safeload_trigger_o = sl_armed_r;

endmodule

// [verification/fpb_checker_asserts.sv]
// Concurrent checks on the ports of the parameter bank access block.
`timescale 1ns/1ns
module fpb_checker
    import fpb_pkg::*;
#(
    parameter int NINSTR = FPB_NINSTR
)
(
    input wire logic                  clock_i,
    input wire logic                  nrst_i,
    input wire logic                  core_running_i,
    input wire logic                  frame_start_i,
    input wire logic [FPB_BANK_W-1:0] active_bank_select_i,
    input wire logic [FPB_NCOPY-1:0]  bank_copy_cmd_i,
    input wire logic [FPB_NCOPY-1:0]  bank_copy_cmd_o,
    input wire logic                  cp_rd_i,
    input wire logic [31:0]           cp_addr_i,
    input wire logic [31:0]           cp_rdata_o,
    input wire logic                  pr_rd_i,
    input wire logic [31:0]           pr_addr_i,
    input wire logic [31:0]           pr_rdata_o,
    input wire logic                  safeload_trigger_i,
    input wire logic                  safeload_trigger_o,
    input wire logic                  cp_access_err_o,
    input wire logic                  pr_access_err_o
);
    // Bank of a mapped parameter word, or 3 for anything outside the parameter map.
    function automatic logic [1:0] bank(logic [31:0] a);
        if (a[31:11] != 21'h1E0040 || a[10:7] == 4'hF || a[6:0] >= NINSTR) return 2'h3;
        return 2'(a[10:7] / 5);
    endfunction
    // Target bank of the lowest set command bit, which is the one that wins.
    function automatic logic [1:0] tgt(logic [5:0] c);
        tgt = 2'h3;
        for (int k = 5; k >= 0; k--)
            if (c[k]) tgt = FPB_COPY_TGT[k];
    endfunction
    wire logic [5:0] low = bank_copy_cmd_i & (~bank_copy_cmd_i + 6'h01);
    wire logic       idle = bank_copy_cmd_o == 6'h00 && bank_copy_cmd_i != 6'h00;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    property p_cp_act;
        core_running_i && cp_rd_i && bank(cp_addr_i) == active_bank_select_i
            |=> cp_rdata_o == 32'h0 && cp_access_err_o;
    endproperty
    a_cp_act: assert property (p_cp_act) else $error("active bank read not zero");
    property p_pr_act;
        core_running_i && pr_rd_i && bank(pr_addr_i) == active_bank_select_i
            |=> pr_rdata_o == 32'h0 && pr_access_err_o;
    endproperty
    a_pr_act: assert property (p_pr_act) else $error("active bank read not zero");
    property p_rd_clash;
        core_running_i && cp_rd_i && pr_rd_i && cp_addr_i == pr_addr_i && bank(cp_addr_i) != 2'h3
            |=> cp_rdata_o == 32'h0 && cp_access_err_o;
    endproperty
    a_rd_clash: assert property (p_rd_clash) else $error("read clash not zeroed");
    property p_stopped;
        !core_running_i |=> !cp_access_err_o && !pr_access_err_o;
    endproperty
    a_stopped: assert property (p_stopped) else $error("error while core stopped");
    property p_accept;
        idle && tgt(bank_copy_cmd_i) != active_bank_select_i |=> bank_copy_cmd_o == $past(low);
    endproperty
    a_accept: assert property (p_accept) else $error("copy command not taken");
    property p_ignore;
        idle && tgt(bank_copy_cmd_i) == active_bank_select_i |=> bank_copy_cmd_o == 6'h00;
    endproperty
    a_ignore: assert property (p_ignore) else $error("copy into active bank taken");
    property p_apply;
        safeload_trigger_o && frame_start_i && !safeload_trigger_i |=> !safeload_trigger_o;
    endproperty
    a_apply: assert property (p_apply) else $error("safeload not applied at frame");
    property p_arm;
        safeload_trigger_i |=> safeload_trigger_o;
    endproperty
    a_arm: assert property (p_arm) else $error("safeload not armed");
    c_copy: cover property (bank_copy_cmd_o != 6'h00 ##1 bank_copy_cmd_o == 6'h00);
    c_err: cover property (cp_access_err_o);
    c_sl: cover property (safeload_trigger_o ##1 !safeload_trigger_o);
endmodule
bind fpb_bank_access fpb_checker #(.NINSTR(NINSTR)) i_fpb_checker (.clock_i, .nrst_i,
    .core_running_i, .frame_start_i, .active_bank_select_i, .bank_copy_cmd_i, .bank_copy_cmd_o,
    .cp_rd_i, .cp_addr_i, .cp_rdata_o, .pr_rd_i, .pr_addr_i, .pr_rdata_o, .safeload_trigger_i,
    .safeload_trigger_o, .cp_access_err_o, .pr_access_err_o);

// [verification/fpb_ctl_model.sv]
// Control-port master model that stages and triggers one safeload.
`timescale 1ns/1ns
module fpb_ctl_model
    import fpb_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        go_i,
    input  wire logic [31:0] idx_i,
    input  wire logic [31:0] seed_i,
    output logic             sl_wr_o,
    output logic [2:0]       sl_sel_o,
    output logic [31:0]      sl_wdata_o,
    output logic             trig_o
);
    initial {sl_wr_o, sl_sel_o, sl_wdata_o, trig_o} = '0;
    // Index first, then the five words, then the trigger; data is scrambled once released.
    always @(posedge go_i)
    begin
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clock_i);
            #1;
            {sl_wr_o, sl_sel_o} = {1'b1, 3'(k)};
            sl_wdata_o = (k == 0) ? idx_i : seed_i + 32'(k);
        end
        @(posedge clock_i);
        #1;
        {sl_wr_o, trig_o, sl_wdata_o} = {2'b01, ~sl_wdata_o};
        @(posedge clock_i);
        #1;
        trig_o = 1'b0;
    end
endmodule

// [verification/testbench.sv]
// Self-checking bench for the parameter bank access block.
`timescale 1ns/1ns
module testbench
    import fpb_pkg::*;
;
    localparam int NI = 4;
    logic        clock_i = 1'b0, nrst_i = 1'b0, core_running_i = 1'b0, frame_start_i = 1'b0;
    logic        cp_rd_i = 1'b0, cp_wr_i = 1'b0, pr_rd_i = 1'b0, pr_wr_i = 1'b0, mr_rd = 1'b0;
    logic        psl_wr_i = 1'b0, go = 1'b0, sl_wr, trig, safeload_trigger_o;
    logic        cp_access_err_o, pr_access_err_o;
    logic [1:0]  active_bank_select_i = 2'h0;
    logic [5:0]  bank_copy_cmd_i = 6'h00, bank_copy_cmd_o;
    logic [2:0]  psl_sel_i = 3'h0, sl_sel;
    logic [31:0] cp_addr_i = '0, cp_wdata_i = '0, pr_addr_i = '0, pr_wdata_i = '0;
    logic [31:0] mr_addr_i = '0, psl_wdata_i = '0, seed = '0, idx = '0;
    logic [31:0] cp_rdata_o, pr_rdata_o, mr_rdata_o, sl_wdata;
    logic [31:0] m [3][5][NI];
    int          err_count = 0, comparisons = 0, nf;
    always #20 clock_i = ~clock_i;
    fpb_bank_access #(.NINSTR(NI)) i_fpb_bank_access (.clock_i, .nrst_i, .core_enable_i(1'b1),
        .core_running_i, .frame_start_i, .active_bank_select_i, .bank_copy_cmd_i,
        .bank_copy_cmd_o, .cp_rd_i, .cp_wr_i, .cp_addr_i, .cp_wdata_i, .cp_rdata_o, .pr_rd_i,
        .pr_wr_i, .pr_addr_i, .pr_wdata_i, .pr_rdata_o, .core_memory_read_instr_i(mr_rd),
        .mr_addr_i, .mr_rdata_o, .sl_wr_i(sl_wr), .sl_sel_i(sl_sel), .sl_wdata_i(sl_wdata),
        .safeload_trigger_i(trig), .safeload_trigger_o, .psl_wr_i, .psl_sel_i, .psl_wdata_i,
        .cp_access_err_o, .pr_access_err_o);
    fpb_ctl_model i_fpb_ctl_model (.clock_i, .go_i(go), .idx_i(idx), .seed_i(seed),
        .sl_wr_o(sl_wr), .sl_sel_o(sl_sel), .sl_wdata_o(sl_wdata), .trig_o(trig));
    task cyc();
        @(posedge clock_i);
        #1;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] ad(int b, int p, int i);
        return FPB_PARAM_BASE + FPB_MEM_STEP * 32'(b * 5 + p) + 32'(i);
    endfunction
    // Strobes both ports at one address for one edge; the next call replaces them.
    task acc(input logic cw, cr, pw, pr, input logic [31:0] a, cd, pd);
        {cp_wr_i, cp_rd_i, pr_wr_i, pr_rd_i} = {cw, cr, pw, pr};
        {cp_addr_i, pr_addr_i, cp_wdata_i, pr_wdata_i} = {a, a, cd, pd};
        cyc();
    endtask
    task frame();
        frame_start_i = 1'b1;
        cyc();
        frame_start_i = 1'b0;
        cyc();
    endtask
    // Stops the core and reads every word through both ports together.
    task ver_all();
        core_running_i = 1'b0;
        foreach (m[b, p, i])
        begin
            acc(0, 1, 0, 1, ad(b, p, i), 0, 0);
            chk(cp_rdata_o, m[b][p][i]);
            chk(pr_rdata_o, m[b][p][i]);
        end
        acc(0, 0, 0, 0, 0, 0, 0);
    endtask
    task finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Main sequence: fill, access rules, every copy, both safeload paths.
    initial
    begin
        void'($urandom(32'h8E52C601));
        repeat (10) cyc();
        nrst_i = 1'b1;
        foreach (m[b, p, i])
        begin
            m[b][p][i] = $urandom;
            acc(1, 0, 0, 0, ad(b, p, i), m[b][p][i], 0);
        end
        ver_all();
        core_running_i = 1'b1;
        acc(1, 0, 0, 0, ad(0, 1, 2), 32'h0000_0BAD, 0);
        chk(32'(cp_access_err_o), 32'h1);
        acc(0, 1, 0, 1, ad(0, 1, 2), 0, 0);
        chk(cp_rdata_o | pr_rdata_o, 32'h0);
        chk(32'(pr_access_err_o), 32'h1);
        {mr_rd, mr_addr_i} = {1'b1, ad(0, 3, 1)};
        acc(0, 1, 0, 1, ad(1, 2, 3), 0, 0);
        chk(mr_rdata_o, 32'h0);
        chk(pr_rdata_o, m[1][2][3]);
        chk(cp_rdata_o, 32'h0);
        mr_addr_i = ad(2, 0, 1);
        cyc();
        chk(mr_rdata_o, m[2][0][1]);
        mr_rd = 1'b0;
        seed = $urandom;
        acc(1, 0, 1, 0, ad(2, 4, 1), ~seed, seed);
        chk(32'(cp_access_err_o), 32'h1);
        m[2][4][1] = seed;
        acc(0, 0, 0, 0, 0, 0, 0);
        for (int c = 0; c < 6; c++)
        begin
            active_bank_select_i = 2'(3 - FPB_COPY_SRC[c] - FPB_COPY_TGT[c]);
            bank_copy_cmd_i = 6'(1 << c);
            cyc();
            bank_copy_cmd_i = 6'h00;
            chk(32'(bank_copy_cmd_o), 32'(1 << c));
            nf = 0;
            for (int n = 0; n < 60 && bank_copy_cmd_o != 6'h00; n++)
            begin
                frame_start_i = (n % 8 == 7);
                nf += int'(frame_start_i);
                cyc();
            end
            frame_start_i = 1'b0;
            chk(32'(nf), 32'h2);
            if (bank_copy_cmd_o != 6'h00)
            begin
                err_count++;
                finish_test();
            end
            m[FPB_COPY_TGT[c]] = m[FPB_COPY_SRC[c]];
        end
        active_bank_select_i = 2'h1;
        bank_copy_cmd_i = 6'h01;
        cyc();
        bank_copy_cmd_i = 6'h00;
        chk(32'(bank_copy_cmd_o), 32'h0);
        frame();
        frame();
        ver_all();
        {core_running_i, active_bank_select_i} = 3'b110;
        idx = $urandom_range(NI - 2);
        seed = $urandom;
        go = 1'b1;
        repeat (9) cyc();
        go = 1'b0;
        chk(32'(safeload_trigger_o), 32'h1);
        frame();
        chk(32'(safeload_trigger_o), 32'h0);
        active_bank_select_i = 2'h0;
        for (int k = 0; k < 6; k++)
        begin
            {psl_wr_i, psl_sel_i} = {1'b1, 3'(k)};
            psl_wdata_i = (k == 0) ? idx : seed - 32'(k);
            cyc();
        end
        psl_wr_i = 1'b0;
        frame();
        for (int p = 0; p < 5; p++)
        begin
            m[2][p][idx] = seed + 32'(p + 1);
            m[0][p][idx] = seed - 32'(p + 1);
        end
        ver_all();
        finish_test();
    end
endmodule
